// file: verilog/gpsp_top.v
// Sixteen-pin general-purpose port with change detection and events
`timescale 1ns/1ps
`default_nettype none
`include "gpsp_defines.vh"
module gpsp_top #(
   parameter PINS = `GPSP_PINS
) (
   input  wire                    ref_clk_i,
   input  wire                    rst_i,
   input  wire                    cfg_req_i,
   input  wire                    cfg_wr_i,
   input  wire [`GPSP_ADDR_W-1:0] cfg_addr_i,
   input  wire [31:0]             cfg_wdata_i,
   output reg  [31:0]             cfg_rdata_o,
   output reg                     cfg_ack_o,
   output reg                     cfg_err_o,
   input  wire [PINS-1:0]         port_input_pin_i,
   output reg  [PINS-1:0]         port_output_pin_o,
   output reg  [PINS-1:0]         port_pins_oe_n_o,
   output reg  [PINS-1:0]         pin_event_o,
   output reg                     cpu_int_o,
   output reg                     dma_event_o
);
   reg  [PINS-1:0]          pin_enable_q;
   reg  [PINS-1:0]          pin_direction_q;
   reg  [PINS-1:0]          out_latch_q;
   reg  [PINS-1:0]          rise_flg_q;
   reg  [PINS-1:0]          rise_msk_q;
   reg  [PINS-1:0]          fall_flg_q;
   reg  [PINS-1:0]          fall_msk_q;
   reg  [`GPSP_GC_W-1:0]    global_q;
   reg  [PINS-1:0]          polarity_q;
   reg  [PINS-1:0]          lvl_prev_q;
   reg                      combined_prev_q;

   wire [PINS-1:0]          lvl;
   wire [PINS-1:0]          in_pins;
   wire [PINS-1:0]          out_pins;
   wire [PINS-1:0]          rise_evt;
   wire [PINS-1:0]          fall_evt;
   wire [PINS-1:0]          delta_hits;
   wire [PINS-1:0]          value_hits;
   wire [PINS-1:0]          sel_hits;
   wire [PINS-1:0]          sel_mask;
   wire [PINS-1:0]          value_read;
   wire                     combined;
   wire                     wr;
   wire                     rd;
   reg                      hit;
   reg  [31:0]              rdata_d;

   // Pins pass the three-stage synchroniser before any use
   gpsp_sync #(
      .WIDTH (PINS)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (port_input_pin_i),
      .level_o   (lvl)
   );

   // Pin roles from enable and direction
   assign in_pins  = pin_enable_q & ~pin_direction_q;
   assign out_pins = pin_enable_q & pin_direction_q;

   // Change detection on enabled input pins only
   assign rise_evt = in_pins & lvl & ~lvl_prev_q;
   assign fall_evt = in_pins & ~lvl & lvl_prev_q;

   // Event modes: delta or value, combined by OR or AND
   assign delta_hits = (rise_flg_q & rise_msk_q) | (fall_flg_q & fall_msk_q);
   assign value_hits = (lvl ^ polarity_q) & rise_msk_q & in_pins;
   assign sel_mask   = global_q[`GPSP_GC_VALUE] ? rise_msk_q : (rise_msk_q | fall_msk_q);
   assign sel_hits   = global_q[`GPSP_GC_VALUE] ? value_hits : delta_hits;
   assign combined   = global_q[`GPSP_GC_AND]
                       ? ((sel_mask != {PINS{1'b0}}) && ((sel_hits & sel_mask) == sel_mask))
                       : (sel_hits != {PINS{1'b0}});

   // Read value: input level for inputs, latch for outputs
   assign value_read = (in_pins & lvl) | (out_pins & out_latch_q);

   // Register bus strobes
   assign wr = cfg_req_i & cfg_wr_i;
   assign rd = cfg_req_i & ~cfg_wr_i;

   // Read decode with unmapped flag
   always @* begin
      hit     = 1'b1;
      rdata_d = 32'h00000000;
      case (cfg_addr_i)
         `GPSP_OFS_ENABLE: begin
            rdata_d[PINS-1:0] = pin_enable_q;
         end
         `GPSP_OFS_DIRECTION: begin
            rdata_d[PINS-1:0] = pin_direction_q;
         end
         `GPSP_OFS_VALUE: begin
            rdata_d[PINS-1:0] = value_read;
         end
         `GPSP_OFS_RISE_FLG: begin
            rdata_d[PINS-1:0] = rise_flg_q;
         end
         `GPSP_OFS_RISE_MSK: begin
            rdata_d[PINS-1:0] = rise_msk_q;
         end
         `GPSP_OFS_FALL_FLG: begin
            rdata_d[PINS-1:0] = fall_flg_q;
         end
         `GPSP_OFS_FALL_MSK: begin
            rdata_d[PINS-1:0] = fall_msk_q;
         end
         `GPSP_OFS_GLOBAL: begin
            rdata_d[`GPSP_GC_W-1:0] = global_q;
         end
         `GPSP_OFS_POLARITY: begin
            rdata_d[PINS-1:0] = polarity_q;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Bus answer, one cycle after the request
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         cfg_rdata_o <= 32'h00000000;
         cfg_ack_o   <= 1'b0;
         cfg_err_o   <= 1'b0;
      end else begin
         cfg_ack_o   <= cfg_req_i;
         cfg_err_o   <= cfg_req_i & ~hit;
         if (rd) begin
            cfg_rdata_o <= hit ? rdata_d : 32'h00000000;
         end
      end
   end

   // Configuration registers
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_enable_q    <= `GPSP_RST_ENABLE;
         pin_direction_q <= `GPSP_RST_DIRECTION;
         out_latch_q     <= `GPSP_RST_ZERO16;
         rise_msk_q      <= `GPSP_RST_ZERO16;
         fall_msk_q      <= `GPSP_RST_ZERO16;
         global_q        <= `GPSP_RST_GLOBAL;
         polarity_q      <= `GPSP_RST_ZERO16;
      end else if (wr) begin
         case (cfg_addr_i)
            `GPSP_OFS_ENABLE: begin
               pin_enable_q <= cfg_wdata_i[PINS-1:0];
            end
            `GPSP_OFS_DIRECTION: begin
               pin_direction_q <= cfg_wdata_i[PINS-1:0];
            end
            `GPSP_OFS_VALUE: begin
               out_latch_q <= cfg_wdata_i[PINS-1:0];
            end
            `GPSP_OFS_RISE_MSK: begin
               rise_msk_q <= cfg_wdata_i[PINS-1:0];
            end
            `GPSP_OFS_FALL_MSK: begin
               fall_msk_q <= cfg_wdata_i[PINS-1:0];
            end
            `GPSP_OFS_GLOBAL: begin
               global_q <= cfg_wdata_i[`GPSP_GC_W-1:0];
            end
            `GPSP_OFS_POLARITY: begin
               polarity_q <= cfg_wdata_i[PINS-1:0];
            end
            default: begin
               out_latch_q <= out_latch_q;
            end
         endcase
      end
   end

   // Change flags: write one to clear, a new change wins
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         rise_flg_q <= `GPSP_RST_ZERO16;
         fall_flg_q <= `GPSP_RST_ZERO16;
         lvl_prev_q <= `GPSP_RST_ZERO16;
      end else begin
         lvl_prev_q <= lvl;
         if (wr && (cfg_addr_i == `GPSP_OFS_RISE_FLG)) begin
            rise_flg_q <= (rise_flg_q & ~cfg_wdata_i[PINS-1:0]) | rise_evt;
         end else begin
            rise_flg_q <= rise_flg_q | rise_evt;
         end
         if (wr && (cfg_addr_i == `GPSP_OFS_FALL_FLG)) begin
            fall_flg_q <= (fall_flg_q & ~cfg_wdata_i[PINS-1:0]) | fall_evt;
         end else begin
            fall_flg_q <= fall_flg_q | fall_evt;
         end
      end
   end

   // Pin drive and event outputs
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         port_output_pin_o <= `GPSP_RST_ZERO16;
         port_pins_oe_n_o  <= ~`GPSP_RST_ZERO16;
         pin_event_o       <= `GPSP_RST_ZERO16;
         combined_prev_q   <= 1'b0;
         cpu_int_o         <= 1'b0;
         dma_event_o       <= 1'b0;
      end else begin
         port_output_pin_o <= out_latch_q & out_pins;
         port_pins_oe_n_o  <= ~out_pins;
         if (global_q[`GPSP_GC_PASS]) begin
            pin_event_o <= (lvl ^ polarity_q) & in_pins;
         end else begin
            pin_event_o <= `GPSP_RST_ZERO16;
         end
         combined_prev_q <= combined;
         cpu_int_o   <= global_q[`GPSP_GC_INT_EN] & combined & ~combined_prev_q;
         dma_event_o <= global_q[`GPSP_GC_INT_EN] & combined & ~combined_prev_q;
      end
   end
endmodule
`default_nettype wire

// file: verilog/gpsp_defines.vh
// Constants for the sixteen-pin general-purpose port
`ifndef GPSP_DEFINES_VH
`define GPSP_DEFINES_VH

`define GPSP_ADDR_W        25
`define GPSP_OFS_ENABLE    25'h1b00000
`define GPSP_OFS_DIRECTION 25'h1b00004
`define GPSP_OFS_VALUE     25'h1b00008
`define GPSP_OFS_RISE_FLG  25'h1b00010
`define GPSP_OFS_RISE_MSK  25'h1b00014
`define GPSP_OFS_FALL_FLG  25'h1b00018
`define GPSP_OFS_FALL_MSK  25'h1b0001c
`define GPSP_OFS_GLOBAL    25'h1b00020
`define GPSP_OFS_POLARITY  25'h1b00024

`define GPSP_PINS          16
`define GPSP_RST_ENABLE    16'h01f9
`define GPSP_RST_DIRECTION 16'h0000
`define GPSP_RST_ZERO16    16'h0000
`define GPSP_RST_GLOBAL    4'h0

`define GPSP_GC_W          4
`define GPSP_GC_AND        0
`define GPSP_GC_VALUE      1
`define GPSP_GC_INT_EN     2
`define GPSP_GC_PASS       3

`define GPSP_MIN_HOLD_IRQ  8
`define GPSP_MIN_HOLD_POLL 12

`endif

// file: verilog/gpsp_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gpsp_sync #(
   parameter WIDTH = 16
) (
   input  wire             ref_clk_i,
   input  wire             rst_i,
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] level_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg lvl_q;
         always @(posedge ref_clk_i) begin
            if (rst_i) begin
               s1_q  <= 1'b0;
               s2_q  <= 1'b0;
               s3_q  <= 1'b0;
               lvl_q <= 1'b0;
            end else begin
               s1_q <= async_i[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // Change counts once stages two and three agree
               if (s2_q == s3_q) begin
                  lvl_q <= s3_q;
               end
            end
         end
         assign level_o[g] = lvl_q;
      end
   endgenerate
endmodule
`default_nettype wire

// file: verification/gpsp_monitor.sv
// Port-level assertions for the sixteen-pin port
`timescale 1ns/1ps
`default_nettype none
`include "gpsp_defines.vh"
module gpsp_monitor #(
   parameter PINS = 16
) (
   input wire logic                    ref_clk_i,
   input wire logic                    rst_i,
   input wire logic                    cfg_req_i,
   input wire logic                    cfg_wr_i,
   input wire logic [`GPSP_ADDR_W-1:0] cfg_addr_i,
   input wire logic [31:0]             cfg_wdata_i,
   input wire logic [31:0]             cfg_rdata_o,
   input wire logic                    cfg_ack_o,
   input wire logic                    cfg_err_o,
   input wire logic [PINS-1:0]         port_input_pin_i,
   input wire logic [PINS-1:0]         port_output_pin_o,
   input wire logic [PINS-1:0]         port_pins_oe_n_o,
   input wire logic [PINS-1:0]         pin_event_o,
   input wire logic                    cpu_int_o,
   input wire logic                    dma_event_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows: assert property (cfg_req_i |=> cfg_ack_o) else $error("no ack");
   a_ack_cause: assert property (cfg_ack_o |-> $past(cfg_req_i)) else $error("stray ack");
   a_err_reserved: assert property (
      cfg_req_i && !cfg_wr_i && cfg_addr_i == 25'h1b0000c |=> cfg_err_o && cfg_rdata_o == 32'h0)
      else $error("reserved read");
   a_err_with_ack: assert property (cfg_err_o |-> cfg_ack_o) else $error("err alone");
   a_out_gated: assert property ((port_output_pin_o & port_pins_oe_n_o) == 0)
      else $error("undriven pin high");
   a_same_event: assert property (cpu_int_o == dma_event_o) else $error("event split");
   a_int_pulse: assert property (cpu_int_o |=> !cpu_int_o) else $error("long pulse");
   a_reset_idle: assert property (
      $fell(rst_i) |-> port_pins_oe_n_o == {PINS{1'b1}} && !cfg_ack_o) else $error("reset idle");
   a_write_output: assert property (
      cfg_req_i && cfg_wr_i && cfg_addr_i == `GPSP_OFS_VALUE ##1 !(cfg_req_i && cfg_wr_i)
      |=> ((port_output_pin_o ^ $past(cfg_wdata_i[PINS-1:0], 2)) & ~port_pins_oe_n_o) == 0)
      else $error("output level");
endmodule
`default_nettype wire

// file: verification/gpsp_pin_model.sv
// Outside source on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpsp_pin_model (
   input  wire logic [15:0] port_output_pin_o,
   input  wire logic [15:0] port_pins_oe_n_o,
   input  wire logic        ref_clk_i,
   output wire logic [15:0] port_input_pin_i
);
   logic [15:0] level_q = 16'h0000;
   // Driven pins follow the port, free pins the outside source
   assign port_input_pin_i = (~port_pins_oe_n_o & port_output_pin_o) | (port_pins_oe_n_o & level_q);
   task automatic drive(input logic [15:0] v);
      @(posedge ref_clk_i);
      level_q <= v;
      repeat (12) @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking testbench for the sixteen-pin port
`timescale 1ns/1ps
`default_nettype none
`include "gpsp_defines.vh"
module tb;
   logic        ref_clk_i   = 1'b0;
   logic        rst_i       = 1'b1;
   logic        req         = 1'b0;
   logic        wr          = 1'b0;
   logic [24:0] addr        = 25'h0;
   logic [31:0] wd          = 32'h0;
   wire  [31:0] rdata;
   wire         ack, err, irq, dma;
   wire  [15:0] pin_i, pin_o, oe_n, pev;
   int          bad_count   = 0;
   int          comparisons = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   gpsp_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cfg_req_i(req), .cfg_wr_i(wr),
      .cfg_addr_i(addr), .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
      .cfg_err_o(err), .port_input_pin_i(pin_i), .port_output_pin_o(pin_o),
      .port_pins_oe_n_o(oe_n), .pin_event_o(pev), .cpu_int_o(irq), .dma_event_o(dma));
   gpsp_pin_model i_pins (.ref_clk_i(ref_clk_i), .port_output_pin_o(pin_o),
      .port_pins_oe_n_o(oe_n), .port_input_pin_i(pin_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [24:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge ref_clk_i);
      req <= 1'b0;
      #1;
      chk({31'h0, ack}, 32'h1);
   endtask
   task automatic rd(input logic [24:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdata, exp);
   endtask
   task automatic ev(input logic [15:0] v, input logic [31:0] exp);
      int n;
      n = 0;
      fork
         i_pins.drive(v);
         repeat (12) begin
            @(posedge ref_clk_i);
            #1 n += irq;
         end
      join
      chk(n, exp);
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic t_reset();
      rd(`GPSP_OFS_ENABLE, 32'h01f9);
      rd(`GPSP_OFS_DIRECTION, 32'h0);
      chk({16'h0, oe_n}, 32'hffff);
      chk({16'h0, pev}, 32'h0);
   endtask
   task automatic t_reserved();
      bus(1'b1, `GPSP_OFS_ENABLE, 32'hffffffff);
      rd(`GPSP_OFS_ENABLE, 32'h0000ffff);
      bus(1'b1, `GPSP_OFS_DIRECTION, 32'hffff00ff);
      rd(`GPSP_OFS_DIRECTION, 32'h000000ff);
      rd(25'h1b0000c, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task automatic t_output();
      bus(1'b1, `GPSP_OFS_VALUE, 32'h0000a5a5);
      repeat (2) @(posedge ref_clk_i);
      chk({16'h0, pin_o}, 32'h00a5);
      chk({16'h0, oe_n}, 32'hff00);
      bus(1'b1, `GPSP_OFS_ENABLE, 32'hfffe);
      repeat (2) @(posedge ref_clk_i);
      chk({16'h0, pin_o}, 32'h00a4);
      chk({16'h0, oe_n}, 32'hff01);
   endtask
   task automatic t_input();
      i_pins.drive(16'h5a00);
      rd(`GPSP_OFS_VALUE, 32'h00005aa4);
   endtask
   task automatic t_events();
      bus(1'b1, `GPSP_OFS_RISE_FLG, 32'hffff);
      bus(1'b1, `GPSP_OFS_RISE_MSK, 32'h0100);
      bus(1'b1, `GPSP_OFS_GLOBAL, 32'h4);
      ev(16'h5b00, 32'h1);
      rd(`GPSP_OFS_RISE_FLG, 32'h0100);
      bus(1'b1, `GPSP_OFS_RISE_FLG, 32'h0100);
      rd(`GPSP_OFS_RISE_FLG, 32'h0);
      bus(1'b1, `GPSP_OFS_FALL_MSK, 32'h0100);
      ev(16'h5a00, 32'h1);
      bus(1'b1, `GPSP_OFS_FALL_FLG, 32'hffff);
      bus(1'b1, `GPSP_OFS_RISE_MSK, 32'h0);
      bus(1'b1, `GPSP_OFS_FALL_MSK, 32'h0);
      ev(16'h5b00, 32'h0);
      bus(1'b1, `GPSP_OFS_RISE_FLG, 32'hffff);
      bus(1'b1, `GPSP_OFS_POLARITY, 32'h0100);
      bus(1'b1, `GPSP_OFS_RISE_MSK, 32'h0100);
      bus(1'b1, `GPSP_OFS_GLOBAL, 32'h6);
      ev(16'h5a00, 32'h1);
   endtask
   task automatic t_modes();
      bus(1'b1, `GPSP_OFS_GLOBAL, 32'h8);
      repeat (2) @(posedge ref_clk_i);
      chk({16'h0, pev}, 32'h5b00);
      bus(1'b1, `GPSP_OFS_RISE_FLG, 32'hffff);
      bus(1'b1, `GPSP_OFS_FALL_FLG, 32'hffff);
      bus(1'b1, `GPSP_OFS_RISE_MSK, 32'h0300);
      bus(1'b1, `GPSP_OFS_GLOBAL, 32'h5);
      ev(16'h5b00, 32'h0);
      ev(16'h5900, 32'h0);
      ev(16'h5b00, 32'h1);
      chk({16'h0, pev}, 32'h0);
   endtask
   task automatic t_midreset();
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_reset();
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_reserved();
      t_output();
      t_input();
      t_events();
      t_modes();
      t_midreset();
      give_verdict();
   end
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
endmodule
bind gpsp_top gpsp_monitor #(.PINS(PINS)) i_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
   .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
   .cfg_err_o(cfg_err_o), .port_input_pin_i(port_input_pin_i),
   .port_output_pin_o(port_output_pin_o), .port_pins_oe_n_o(port_pins_oe_n_o),
   .pin_event_o(pin_event_o), .cpu_int_o(cpu_int_o), .dma_event_o(dma_event_o));
`default_nettype wire
